// >>> logic/uft_pkg.sv
// uft_pkg: constants, register offsets and carrier types for the uart channel
package uft_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_DATA   = 5'h00;
	localparam logic [4:0] OFS_IER    = 5'h04;
	localparam logic [4:0] OFS_IIR    = 5'h08;
	localparam logic [4:0] OFS_LCR    = 5'h0C;
	localparam logic [4:0] OFS_MCR    = 5'h10;
	localparam logic [4:0] OFS_LSR    = 5'h14;
	localparam logic [4:0] OFS_MSR    = 5'h18;
	localparam logic [4:0] OFS_SCR    = 5'h1C;

	// ----------------------------------------------------------------
	// reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] IIR_RESET  = 8'h01;
	localparam logic [7:0] LSR_RESET  = 8'h60;
	localparam logic [3:0] ID_NONE    = 4'h1;
	localparam logic [3:0] ID_RLS     = 4'h6;
	localparam logic [3:0] ID_RDA     = 4'h4;
	localparam logic [3:0] ID_TMO     = 4'hC;
	localparam logic [3:0] ID_TX_HOLDING_EMPTY    = 4'h2;
	localparam logic [3:0] ID_MSI     = 4'h0;
	localparam int         LCR_DIVISOR_ACCESS_SELECT   = 7;
	localparam int         LCR_STB    = 2;
	localparam int         LCR_BREAK  = 6;
	localparam int         MCR_LOOP   = 4;
	localparam logic [15:0] HS_BIT    = 16'h8000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam real  CLK_MHZ          = 200.0;
	localparam real  BRG_MHZ          = 1.8462;
	// phase accumulator step giving the brg input enable from pclk
	localparam logic [31:0] BRG_STEP  = 32'(int'(BRG_MHZ / CLK_MHZ * 4294967296.0));
	localparam int   FIFO_DEPTH       = 16;
	localparam logic [4:0] FIFO_FULL  = 5'h10;
	localparam int   TMO_CHARS        = 4;
	localparam logic [3:0] SAMPLE_MID = 4'h7;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_SHIFT = 3'b010,
		RX_STOP  = 3'b100
	} uft_rx_state_t;

	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic ri_n;
		logic dcd_n;
	} uft_modem_in_t;

	typedef struct packed {
		logic request_send_n;
		logic terminal_ready_n;
		logic aux_out_one_n;
		logic aux_out_two_n;
	} uft_modem_out_t;

endpackage

// >>> logic/uft_uart.sv
// uft_uart: one 16550-style uart channel with fifos, interrupt ident and apb slave
// ----------------------------------------------------------------
// Summary of operation
// RL1: divisor 12/1 standard, 32770/32769 high speed
// RL2: brg fed by 1.8462 MHz enable, sixteen-bit divisor
// RL3: divisor byte write reloads baud counter at once
// RL4: divisor 0 divides by 3, 2 by 2
// RL5: reset clears ier fcr lcr mcr, iir reads 01
// RL6: reset lsr reads only bits 5 and 6 set
// RL7: reset clears modem deltas, upper bits track inputs
// RL8: reset drives outputs high, empties fifos; port_irq is reset low
// RL9: rx fifo interrupts need fifo and rx enables
// RL10: rx data interrupt follows trigger level occupancy
// RL11: line status outranks received data available
// RL12: data ready set on push, cleared when empty
// RL13: timeout after four idle character times
// RL14: second stop bit counts in character time
// RL15: character times counted from receiver clock
// RL16: cpu read clears timeout and restarts timer
// RL17: new character or read restarts timer
// RL18: tx fifo interrupts need fifo and tx enables
// RL19: tx empty interrupt cleared by write or ident read
// RL20: single-byte empty indication delayed one character
// RL21: fifo enable change raises tx interrupt at once
// RL22: timeout shares rx priority, tx empty shares tx
// ----------------------------------------------------------------
module uft_uart
	import uft_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [4:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial and modem pins
	input  wire logic        serial_in,
	input  wire uft_modem_in_t modem_in,
	output logic             serial_out_a,
	output logic             serial_out_b,
	output uft_modem_out_t   modem_out,
	output logic             port_irq
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync1, sync2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 5'h1F;
			sync2 <= 5'h1F;
		end else begin
			sync1 <= {serial_in, modem_in};
			sync2 <= sync1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  irq_enable_reg, fifo_ctrl_reg, line_ctrl_reg, modem_ctrl_reg, scratch;
	logic [7:0]  divisor_low_byte, divisor_high_byte;
	logic [3:0]  msr_delta;
	logic [3:0]  lsr_err;
	logic        divisor_access_select;
	logic        fifo_enable_bit;
	assign divisor_access_select = line_ctrl_reg[LCR_DIVISOR_ACCESS_SELECT];
	assign fifo_enable_bit       = fifo_ctrl_reg[0];

	logic wr, rd;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	logic wr_data, rd_data, wr_fcr, rd_iir, rd_lsr, rd_msr, wr_dll, wr_dlm;
	assign wr_data = wr && paddr == OFS_DATA && !divisor_access_select;
	assign rd_data = rd && paddr == OFS_DATA && !divisor_access_select;
	assign wr_dll  = wr && paddr == OFS_DATA && divisor_access_select;
	assign wr_dlm  = wr && paddr == OFS_IER && divisor_access_select;
	assign wr_fcr  = wr && paddr == OFS_IIR;
	assign rd_iir  = rd && paddr == OFS_IIR;
	assign rd_lsr  = rd && paddr == OFS_LSR;
	assign rd_msr  = rd && paddr == OFS_MSR;

	logic rx_clear, tx_clear;
	// fifo reset bits act only with enable set; dropping enable also empties
	assign rx_clear = wr_fcr && ((pwdata[1] && pwdata[0]) || (!pwdata[0] && fifo_enable_bit)); // RL8
	assign tx_clear = wr_fcr && ((pwdata[2] && pwdata[0]) || (!pwdata[0] && fifo_enable_bit)); // RL8

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= 8'h00; // RL5
			fifo_ctrl_reg  <= 8'h00; // RL5
			line_ctrl_reg  <= 8'h00; // RL5
			modem_ctrl_reg <= 8'h00; // RL5
			scratch        <= 8'h00;
			divisor_low_byte  <= 8'h00;
			divisor_high_byte <= 8'h00;
		end else if (wr) begin
			case (paddr)
				OFS_DATA: if (divisor_access_select) divisor_low_byte <= pwdata[7:0];
				OFS_IER: begin
					if (divisor_access_select)
						divisor_high_byte <= pwdata[7:0];
					else
						irq_enable_reg <= {4'h0, pwdata[3:0]};
				end
				OFS_IIR: fifo_ctrl_reg <= {pwdata[7:6], 5'h00, pwdata[0]};
				OFS_LCR: line_ctrl_reg <= pwdata[7:0];
				OFS_MCR: modem_ctrl_reg <= {3'h0, pwdata[4:0]};
				OFS_SCR: scratch <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// baud generator: 1.8462 MHz enable, divisor counter, 16x tick
	// ----------------------------------------------------------------
	logic [31:0] phase;
	logic [31:0] brg_step;
	logic        brg_in;
	logic [15:0] divisor, eff_div, baud_cnt;
	assign divisor = {divisor_high_byte, divisor_low_byte};
	// one 16x tick per input edge is the ceiling, so the fast codes raise the input rate
	always_comb begin
		if (divisor == (HS_BIT | 16'h0001))
			brg_step = BRG_STEP << 2; // RL1
		else if (divisor == (HS_BIT | 16'h0002))
			brg_step = BRG_STEP << 1; // RL1
		else
			brg_step = BRG_STEP;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase  <= 32'h0;
			brg_in <= 1'b0;
		end else begin
			{brg_in, phase} <= {1'b0, phase} + {1'b0, brg_step}; // RL2
		end
	end

	logic        tick16;
	// high-speed bit marks the fast codes: 32770 -> 230400, 32769 -> 460800
	always_comb begin
		if (divisor == (HS_BIT | 16'h0002))
			eff_div = 16'h0001;
		else if (divisor == (HS_BIT | 16'h0001))
			eff_div = 16'h0001;
		else if (divisor == 16'h0000)
			eff_div = 16'h0003; // RL4
		else
			eff_div = divisor; // RL1
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt <= 16'h0001;
			tick16   <= 1'b0;
		end else if (wr_dll || wr_dlm) begin
			baud_cnt <= 16'h0001; // RL3
			tick16   <= 1'b0;
		end else if (brg_in) begin
			tick16   <= baud_cnt <= 16'h0001;
			baud_cnt <= (baud_cnt <= 16'h0001) ? eff_div : baud_cnt - 16'h0001;
		end else begin
			tick16 <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// fifos (flip-flop storage) and character length
	// ----------------------------------------------------------------
	logic [3:0] nbits;
	assign nbits = 4'h5 + {2'h0, line_ctrl_reg[1:0]} + {3'h0, line_ctrl_reg[3]};
	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [3:0] rx_wp, rx_rp, tx_wp, tx_rp;
	logic [4:0] rx_cnt, tx_cnt;
	logic       rx_push, tx_pop;
	logic [7:0] rx_byte;
	logic       tx_wr_ok;
	assign tx_wr_ok = wr_data && tx_cnt != FIFO_FULL;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00; // RL8
		end else if (rx_clear) begin
			rx_wp  <= 4'h0;
			rx_rp  <= 4'h0;
			rx_cnt <= 5'h00; // RL8
		end else begin
			if (rx_push && rx_cnt != FIFO_FULL) begin
				rx_mem[rx_wp] <= rx_byte;
				rx_wp <= rx_wp + 4'h1;
			end
			if (rd_data && rx_cnt != 5'h00)
				rx_rp <= rx_rp + 4'h1;
			rx_cnt <= rx_cnt + 5'((rx_push && rx_cnt != FIFO_FULL) ? 1 : 0)
				- 5'((rd_data && rx_cnt != 5'h00) ? 1 : 0);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00; // RL8
		end else if (tx_clear) begin
			tx_wp  <= 4'h0;
			tx_rp  <= 4'h0;
			tx_cnt <= 5'h00; // RL8
		end else begin
			if (tx_wr_ok) begin
				tx_mem[tx_wp] <= pwdata[7:0];
				tx_wp <= tx_wp + 4'h1;
			end
			if (tx_pop)
				tx_rp <= tx_rp + 4'h1;
			tx_cnt <= tx_cnt + 5'(tx_wr_ok ? 1 : 0) - 5'(tx_pop ? 1 : 0);
		end
	end

	// ----------------------------------------------------------------
	// receiver: 16x oversampling, start, data, parity, stop
	// ----------------------------------------------------------------
	uft_rx_state_t rx_state;
	logic [3:0] rx_sub, rx_bit;
	logic [8:0] rx_sh;
	logic       rx_line;
	assign rx_line = modem_ctrl_reg[MCR_LOOP] ? serial_out_a : sync2[4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= RX_IDLE;
			rx_sub   <= 4'h0;
			rx_bit   <= 4'h0;
			rx_sh    <= 9'h000;
			rx_push  <= 1'b0;
			rx_byte  <= 8'h00;
			lsr_err  <= 4'h0;
		end else begin
			rx_push <= 1'b0;
			if (rd_lsr)
				lsr_err <= 4'h0;
			if (tick16) begin
				case (rx_state)
					RX_IDLE: begin
						rx_sub <= rx_line ? 4'h0 : rx_sub + 4'h1;
						if (!rx_line && rx_sub == SAMPLE_MID) begin
							rx_state <= RX_SHIFT;
							rx_sub   <= 4'h0;
							rx_bit   <= 4'h0;
						end
					end
					RX_SHIFT: begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == 4'hF) begin
							rx_sh  <= {rx_line, rx_sh[8:1]};
							rx_bit <= rx_bit + 4'h1;
							if (rx_bit + 4'h1 == nbits)
								rx_state <= RX_STOP;
						end
					end
					RX_STOP: begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == 4'hF) begin
							rx_state <= RX_IDLE;
							rx_sub   <= 4'h0;
							rx_push  <= 1'b1; // RL12
							rx_byte  <= 8'(rx_sh >> (4'h9 - nbits));
							lsr_err[2] <= !rx_line;
							lsr_err[0] <= rx_cnt == FIFO_FULL;
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// transmitter: frame counted in 16x ticks
	// ----------------------------------------------------------------
	logic [7:0] tx_sub;
	logic [11:0] tx_frame;
	logic       tx_busy, tx_bit;
	logic [7:0] frame_ticks;
	logic [11:0] tx_word;
	logic [3:0]  data_bits;
	assign data_bits = 4'h5 + {2'h0, line_ctrl_reg[1:0]};
	// unused data bits go out at stop level; parity follows the last data bit
	always_comb begin
		tx_word = 12'hFFF;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < data_bits)
				tx_word[i] = tx_mem[tx_rp][i];
		end
		if (line_ctrl_reg[3])
			tx_word[data_bits] = ^(tx_mem[tx_rp] & (8'hFF >> (4'h8 - data_bits))) ^ !line_ctrl_reg[4];
	end
	// start + data + parity + stop bits, in 16x ticks
	assign frame_ticks = 8'({4'h0, nbits + 4'h2 + {3'h0, line_ctrl_reg[LCR_STB]}} << 4);
	assign tx_pop = !tx_busy && tx_cnt != 5'h00 && tick16;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy  <= 1'b0;
			tx_sub   <= 8'h00;
			tx_frame <= 12'hFFF;
			tx_bit   <= 1'b1;
		end else if (tick16) begin
			if (tx_pop) begin
				tx_busy  <= 1'b1;
				tx_sub   <= 8'h00;
				tx_frame <= tx_word;
				tx_bit   <= 1'b0;
			end else if (tx_busy) begin
				tx_sub <= tx_sub + 8'h01;
				if (tx_sub[3:0] == 4'hF) begin
					tx_bit   <= tx_frame[0];
					tx_frame <= {1'b1, tx_frame[11:1]};
				end
				if (tx_sub + 8'h01 == frame_ticks)
					tx_busy <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// character-time timeout (receiver clock based)
	// ----------------------------------------------------------------
	logic [9:0] tmo_cnt;
	logic       tmo_irq;
	logic [9:0] tmo_limit;
	// four frames including any second stop bit, in 16x ticks
	assign tmo_limit = 10'(TMO_CHARS) * {2'h0, frame_ticks}; // RL14
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_cnt <= 10'h000;
			tmo_irq <= 1'b0;
		end else if (rx_push || rd_data || rx_cnt == 5'h00) begin
			tmo_cnt <= 10'h000; // RL17
			tmo_irq <= 1'b0;    // RL16
		end else if (tick16) begin // RL15
			if (tmo_cnt >= tmo_limit)
				tmo_irq <= 1'b1; // RL13
			else
				tmo_cnt <= tmo_cnt + 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// transmit empty indication and its interrupt
	// ----------------------------------------------------------------
	logic tx_holding_empty_flag, tx_holding_empty_irq, multi_seen, fen_q;
	logic [3:0] iir_id;
	logic [7:0] tx_holding_empty_delay;
	logic       tx_empty_now;
	assign tx_empty_now = tx_cnt == 5'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_empty_flag  <= 1'b1; // RL6
			tx_holding_empty_irq   <= 1'b0;
			multi_seen <= 1'b0;
			tx_holding_empty_delay <= 8'h00;
			fen_q      <= 1'b0;
		end else begin
			fen_q <= fifo_enable_bit;
			if (tx_cnt >= 5'h02)
				multi_seen <= 1'b1;
			if (tx_wr_ok) begin
				tx_holding_empty_flag  <= 1'b0;
				tx_holding_empty_irq   <= 1'b0; // RL19
				tx_holding_empty_delay <= 8'h00;
			end else if (fen_q != fifo_enable_bit && tx_empty_now) begin
				tx_holding_empty_flag <= 1'b1;
				tx_holding_empty_irq  <= 1'b1; // RL21
			end else if (tx_empty_now && !tx_holding_empty_flag) begin
				// lone byte: hold off one frame less the last stop bit
				if (multi_seen || tx_holding_empty_delay >= frame_ticks - 8'h10) begin // RL20
					tx_holding_empty_flag  <= 1'b1;
					tx_holding_empty_irq   <= 1'b1; // RL19
					multi_seen <= 1'b0;
				end else if (tick16)
					tx_holding_empty_delay <= tx_holding_empty_delay + 8'h01;
			end else if (rd_iir && iir_id == ID_TX_HOLDING_EMPTY)
				tx_holding_empty_irq <= 1'b0; // RL19
		end
	end

	// ----------------------------------------------------------------
	// interrupt identification and priority
	// ----------------------------------------------------------------
	logic [7:0] rx_trig;
	logic       rda_irq;
	always_comb begin
		case (fifo_ctrl_reg[7:6])
			2'h0:    rx_trig = 8'h01;
			2'h1:    rx_trig = 8'h04;
			2'h2:    rx_trig = 8'h08;
			default: rx_trig = 8'h0E;
		endcase
	end
	// trigger level only in fifo mode, otherwise any byte
	assign rda_irq = fifo_enable_bit ? ({3'h0, rx_cnt} >= rx_trig) : rx_cnt != 5'h00; // RL10
	always_comb begin
		if (irq_enable_reg[2] && lsr_err != 4'h0)
			iir_id = ID_RLS; // RL11
		else if (irq_enable_reg[0] && rda_irq) // RL9
			iir_id = ID_RDA; // RL22
		else if (irq_enable_reg[0] && fifo_enable_bit && tmo_irq) // RL9
			iir_id = ID_TMO; // RL22
		else if (irq_enable_reg[1] && tx_holding_empty_irq) // RL18
			iir_id = ID_TX_HOLDING_EMPTY; // RL22
		else if (irq_enable_reg[3] && msr_delta != 4'h0)
			iir_id = ID_MSI;
		else
			iir_id = ID_NONE;
	end

	// ----------------------------------------------------------------
	// modem status deltas; set wins over read clear
	// ----------------------------------------------------------------
	logic [3:0] msr_now, msr_prev;
	assign msr_now = modem_ctrl_reg[MCR_LOOP] ?
		{modem_ctrl_reg[3], modem_ctrl_reg[2], modem_ctrl_reg[0], modem_ctrl_reg[1]} :
		~{sync2[0], sync2[1], sync2[2], sync2[3]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msr_delta <= 4'h0; // RL7
			msr_prev  <= 4'h0;
		end else begin
			msr_prev  <= msr_now;
			msr_delta <= (rd_msr ? 4'h0 : msr_delta)
				| {msr_now[3] ^ msr_prev[3], msr_prev[2] & !msr_now[2],
				   msr_now[1] ^ msr_prev[1], msr_now[0] ^ msr_prev[0]};
		end
	end

	// ----------------------------------------------------------------
	// apb read mux and pins
	// ----------------------------------------------------------------
	logic [7:0] lsr_val;
	assign lsr_val = {fifo_enable_bit && lsr_err != 4'h0, tx_holding_empty_flag && !tx_busy, tx_holding_empty_flag,
		lsr_err, rx_cnt != 5'h00}; // RL12
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// zero wait: ready rises in the access cycle's first edge
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					OFS_DATA: prdata <= {24'h0, divisor_access_select ? divisor_low_byte : rx_mem[rx_rp]};
					OFS_IER:  prdata <= {24'h0, divisor_access_select ? divisor_high_byte : irq_enable_reg};
					OFS_IIR:  prdata <= {24'h0, {2{fifo_enable_bit}}, 2'h0, iir_id}; // RL5
					OFS_LCR:  prdata <= {24'h0, line_ctrl_reg};
					OFS_MCR:  prdata <= {24'h0, modem_ctrl_reg};
					OFS_LSR:  prdata <= {24'h0, lsr_val};
					OFS_MSR:  prdata <= {24'h0, msr_now, msr_delta}; // RL7
					OFS_SCR:  prdata <= {24'h0, scratch};
					default:  prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_a <= 1'b1; // RL8
			serial_out_b <= 1'b1; // RL8
			modem_out    <= 4'hF; // RL8
			port_irq     <= 1'b0; // RL8
		end else begin
			serial_out_a <= (tx_bit || !tx_busy) && !line_ctrl_reg[LCR_BREAK];
			serial_out_b <= (tx_bit || !tx_busy) && !line_ctrl_reg[LCR_BREAK];
			modem_out    <= modem_ctrl_reg[MCR_LOOP] ? 4'hF :
				~{modem_ctrl_reg[1], modem_ctrl_reg[0], modem_ctrl_reg[2], modem_ctrl_reg[3]};
			port_irq     <= iir_id != ID_NONE && modem_ctrl_reg[3];
		end
	end

endmodule // uft_uart

// >>> test/uft_chk.sv
// uft_chk: port-level assertions for the uart channel
module uft_chk
	import uft_pkg::*;
(
	// apb
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	// pins
	input wire logic           serial_out_a,
	input wire logic           serial_out_b,
	input wire uft_modem_out_t modem_out,
	input wire logic           port_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	rst_pins_a: assert property ($rose(presetn) |-> serial_out_a && modem_out == 4'hF && !port_irq)
		else $error("pins not idle after reset");
	ready_answer_a: assert property (psel && !penable |=> pready)
		else $error("no zero-wait answer");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	no_error_a: assert property (!pslverr)
		else $error("error response");
	read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read upper bits set");
	out_pair_a: assert property (serial_out_a == serial_out_b)
		else $error("serial outputs differ");
	irq_gate_a: assert property (port_irq |-> !modem_out.aux_out_two_n)
		else $error("irq without aux two");
	// a bit lasts hundreds of clocks, so a short start bit is a glitch
	start_bit_a: assert property ($fell(serial_out_a) |-> !serial_out_a [*8])
		else $error("start bit too short");
endmodule // uft_chk

bind uft_uart uft_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_a(serial_out_a),
	.serial_out_b(serial_out_b), .modem_out(modem_out), .port_irq(port_irq));

// >>> test/uft_remote.sv
// uft_remote: remote serial device on the receive and transmit lines
module uft_remote
	import uft_pkg::*;
#(
	parameter int BIT_CLKS = 433
)
(
	// clock
	input  wire logic     pclk,
	// serial side
	input  wire logic     line_in,
	output logic          line_out,
	output uft_modem_in_t modem_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		line_out = 1'b1;
		modem_lines = 4'hF;
	end

	// one 8n1 frame, lsb first; the line idles high between frames
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BIT_CLKS) @(posedge pclk);
		end
	endtask

	// samples mid-bit, returns at the middle of the stop bit
	task automatic recv(output logic [7:0] b);
		while (line_in) @(posedge pclk);
		repeat (BIT_CLKS / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge pclk);
			b[i] = line_in;
		end
		repeat (BIT_CLKS) @(posedge pclk);
	endtask
endmodule // uft_remote

// >>> test/testbench.sv
// testbench: reset state, divisor, rx fifo interrupts, timeout and transmit
module testbench
	import uft_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int  BIT = 433;
	localparam int  FRAME = 10 * BIT;
	logic           pclk, presetn, psel, penable, pwrite;
	logic [4:0]     paddr;
	logic [31:0]    pwdata, prdata;
	logic           pready, pslverr, serial_in, serial_out_a, serial_out_b, port_irq;
	uft_modem_in_t  modem_in;
	uft_modem_out_t modem_out;
	logic [31:0]    exp_q[$];
	int             err_total, num_checks, cyc;
	logic [7:0]     b, r;
	logic [3:0]     v;

	uft_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in(serial_in), .modem_in(modem_in), .serial_out_a(serial_out_a),
		.serial_out_b(serial_out_b), .modem_out(modem_out), .port_irq(port_irq));
	uft_remote #(.BIT_CLKS(BIT)) rem (.pclk(pclk), .line_in(serial_out_a), .line_out(serial_in),
		.modem_lines(modem_in));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge: no double assignment and the read monitor has popped
		@(posedge pclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wait_irq(input logic lvl, input int n);
		for (int i = 0; i < n && port_irq !== lvl; i++) @(posedge pclk);
		chk(32'(port_irq), 32'(lvl));
	endtask

	// read data is compared in the edge that completes the access
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
			chk(prdata, exp_q.pop_front());
	end

	// hang guard: the run needs well under half of this
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 100000) begin
			err_total++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 5'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		void'($urandom(26968));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'({serial_out_a, serial_out_b, modem_out, port_irq}), 32'h7E);
		rd(OFS_IER, 32'h00);
		rd(OFS_IIR, 32'(IIR_RESET));
		rd(OFS_LCR, 32'h00);
		rd(OFS_MCR, 32'h00);
		rd(OFS_LSR, 32'(LSR_RESET));
		rd(OFS_MSR, 32'h00);
		v = 4'($urandom);
		rem.modem_lines <= v;
		repeat (6) @(posedge pclk);
		rd(OFS_MSR, 32'({~v[0], ~v[1], ~v[2], ~v[3], ~v[0], 1'b0, ~v[2], ~v[3]}));
		rd(OFS_MSR, 32'({~v[0], ~v[1], ~v[2], ~v[3], 4'h0}));
		$display("reset test done");

		// divisor 32769 for the top rate
		wr(OFS_LCR, 32'h80);
		wr(OFS_DATA, 32'h01);
		wr(OFS_IER, 32'h80);
		rd(OFS_DATA, 32'h01);
		rd(OFS_IER, 32'h80);
		wr(OFS_LCR, 32'h03);
		v = 4'($urandom) | 4'h8;
		wr(OFS_MCR, 32'(v));
		rd(OFS_MCR, 32'(v));
		@(posedge pclk);
		chk(32'(modem_out), 32'({~v[1], ~v[0], ~v[2], ~v[3]}));
		$display("divisor test done");

		// rx trigger level 1, interrupt held back until enabled
		wr(OFS_IIR, 32'h07);
		b = 8'($urandom);
		rem.send(b);
		chk(32'(port_irq), 32'h0);
		rd(OFS_IIR, 32'hC1);
		wr(OFS_IER, 32'h01);
		wait_irq(1'b1, 8);
		rd(OFS_IIR, 32'hC4);
		rd(OFS_LSR, 32'h61);
		rd(OFS_DATA, 32'(b));
		rd(OFS_LSR, 32'h60);
		wait_irq(1'b0, 8);
		$display("rx trigger test done");

		// trigger 14 never reached: only the timeout can fire
		wr(OFS_IIR, 32'hC1);
		b = 8'($urandom);
		rem.send(b);
		repeat (3 * FRAME) @(posedge pclk);
		chk(32'(port_irq), 32'h0);
		wait_irq(1'b1, 2 * FRAME);
		rd(OFS_IIR, 32'hCC);
		rd(OFS_DATA, 32'(b));
		rd(OFS_IIR, 32'hC1);
		$display("timeout test done");

		// transmit empty interrupt, cleared by ident read, low during a lone byte and raised again after it
		wr(OFS_IER, 32'h02);
		wait_irq(1'b1, 8);
		rd(OFS_IIR, 32'hC2);
		rd(OFS_IIR, 32'hC1);
		b = 8'($urandom);
		wr(OFS_DATA, 32'(b));
		fork
			rem.recv(r);
			begin
				repeat (5 * BIT) @(posedge pclk);
				chk(32'(port_irq), 32'h0);
			end
		join
		chk(32'(r), 32'(b));
		wait_irq(1'b1, FRAME);
		$display("tx test done");

		// rx fifo clear through fifo control
		rem.send(8'($urandom));
		wr(OFS_IIR, 32'h03);
		rd(OFS_LSR, 32'h60);
		$display("fifo clear test done");
		chk(32'(exp_q.size()), 32'h0);
		end_sim();
	end
endmodule // testbench
